// ===== ecs_params.svh
// Constants for the error code and setting sync block
`ifndef ECS_PARAMS_SVH
`define ECS_PARAMS_SVH

`define ECS_ADDR_GATE     16'h06d5
`define ECS_ADDR_SAMPLE   16'h06d6
`define ECS_ADDR_POSCHG   16'h06d7
`define ECS_ERR_OFFSET    16'h03e8
`define ECS_ERR_NONE      16'h0000
`define ECS_ACCESS_CODE   16'h0001
`define ECS_CLR_HOLD      4'h3
`define ECS_FAST_BLINK_NS 100000000
`define ECS_CLK_NS        8
`define ECS_BLINK_CYC     (`ECS_FAST_BLINK_NS / `ECS_CLK_NS)
`define ECS_GATE_MAX      16'h270f
`define ECS_SAMPLE_MAX    16'h270f
`define ECS_POSCHG_MAX    16'h0001

`endif

// ===== ecs_pkg.sv
// Types shared by the error code and setting sync block
package ecs_pkg;
  typedef enum logic [3:0] {
    ECS_IDLE = 4'b0001,
    ECS_LOAD = 4'b0010,
    ECS_SAVE = 4'b0100,
    ECS_WAIT = 4'b1000
  } ecs_state_t;

  // Host side buffer write
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [15:0] data;
  } ecs_wr_t;

  // Sync commands to internal store
  typedef struct packed {
    logic load;
    logic save;
  } ecs_sync_t;
endpackage

// ===== ecs_blink.sv
// Fast blink generator for the error indicator
`timescale 1ns/1ps
`default_nettype none
`include "ecs_params.svh"
module ecs_blink #(
  parameter int unsigned HALF_CYC = `ECS_BLINK_CYC
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic clk_en,
  // Control
  input  wire logic enable,
  output logic      blink
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        lvl;
  } ecs_blink_st_t;

  ecs_blink_st_t st_q;
  ecs_blink_st_t st_d;

  always_comb
  begin
    st_d = st_q;
    if (!enable)
    begin
      st_d.cnt = '0;
      st_d.lvl = 1'b0;
    end
    else if (st_q.cnt >= HALF_CYC - 1)
    begin
      st_d.cnt = '0;
      st_d.lvl = ~st_q.lvl;
    end
    else
    begin
      st_d.cnt = 32'(st_q.cnt + 32'h1);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      st_q <= '0;
    else if (clk_en)
      st_q <= st_d;
  end

  assign blink = st_q.lvl;
endmodule
`default_nettype wire

// ===== ecs_top.sv
// Error code latch, indicator and setting sync control
`timescale 1ns/1ps
`default_nettype none
`include "ecs_params.svh"
module ecs_top #(
  parameter int unsigned BLINK_HALF = `ECS_BLINK_CYC
) (
  // Clock and reset
  input  wire logic           sys_clk,
  input  wire logic           nrst,
  input  wire logic           clk_en,
  // Host state
  input  wire logic           host_reset,
  input  wire logic           host_stopped,
  input  wire logic           power_ok,
  input  wire logic           error_clear_request,
  // Error events
  input  wire logic           err_valid,
  input  wire logic [15:0]    err_code,
  input  wire logic           access_err,
  // Host buffer writes and rewrite request
  input  wire ecs_pkg::ecs_wr_t buf_wr,
  input  wire logic           init_write_done,
  input  wire logic           rewrite_req,
  input  wire logic           store_done,
  // Outputs
  output logic [15:0]         err_code_word,
  output logic                err_flag,
  output logic                err_led,
  output ecs_pkg::ecs_sync_t  sync_cmd,
  output logic                busy
);
  import ecs_pkg::*;

  typedef struct packed {
    ecs_state_t  state;
    logic [15:0] code;
    logic        flag;
    logic        acc;
    logic [3:0]  clr_cnt;
    logic        host_rst_prev;
    logic        init_pend;
    logic [15:0] bad_addr;
    logic        bad;
    ecs_sync_t   cmd;
    logic        led;
    logic        busy;
  } ecs_st_t;

  ecs_st_t st_q;
  ecs_st_t st_d;
  logic        blink;
  logic        chk_bad;
  logic        clr_held;
  logic        clr_any;
  logic        host_leave;
  logic        range_hit;
  logic [15:0] range_code;
  logic        load_trig;
  logic        wait_exit;

  ecs_blink #(
    .HALF_CYC (BLINK_HALF)
  ) u_blink (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .clk_en  (clk_en),
    .enable  (st_q.acc),
    .blink   (blink)
  );

  // Range check on the guarded setting words
  always_comb
  begin
    chk_bad = 1'b0;
    if (buf_wr.valid)
    begin
      unique case (buf_wr.addr)
        `ECS_ADDR_GATE:   chk_bad = (buf_wr.data > `ECS_GATE_MAX);
        `ECS_ADDR_SAMPLE: chk_bad = (buf_wr.data > `ECS_SAMPLE_MAX);
        `ECS_ADDR_POSCHG: chk_bad = (buf_wr.data > `ECS_POSCHG_MAX);
        default:          chk_bad = 1'b0;
      endcase
    end
  end

  // Qualified triggers shared by the state update
  always_comb
  begin
    // Counter saturated and request still held
    clr_held = 1'b0;
    if (error_clear_request && (st_q.clr_cnt == `ECS_CLR_HOLD))
      clr_held = 1'b1;

    // Any of the three clearing causes
    clr_any = clr_held || host_reset || !power_ok;

    // Falling edge of the host reset level
    host_leave = st_q.host_rst_prev && !host_reset;

    // Pending bad word, or one with the completion strobe
    range_hit = init_write_done && (st_q.bad || chk_bad);

    // First bad address since last completion wins
    if (st_q.bad)
      range_code = 16'(st_q.bad_addr + `ECS_ERR_OFFSET);
    else
      range_code = 16'(buf_wr.addr + `ECS_ERR_OFFSET);

    // Copy out after power-on or stopped-host reset
    load_trig = st_q.init_pend || (host_reset && host_stopped);

    // Leave the wait only with the host out of reset
    wait_exit = store_done && !host_reset;
  end

  always_comb
  begin
    st_d = st_q;
    st_d.cmd = '0;
    st_d.host_rst_prev = host_reset;

    // Remember a bad word until initial data write completes
    if (chk_bad && !st_q.bad)
    begin
      st_d.bad = 1'b1;
      st_d.bad_addr = buf_wr.addr;
    end

    // Level request must be held, single pulse ignored
    if (error_clear_request)
    begin
      if (st_q.clr_cnt != `ECS_CLR_HOLD)
        st_d.clr_cnt = 4'(st_q.clr_cnt + 4'h1);
    end
    else
      st_d.clr_cnt = '0;

    // Code stays put unless a clear qualifies
    if (clr_any)
      st_d.code = `ECS_ERR_NONE;
    if (host_leave)
    begin
      st_d.flag = 1'b0;
      st_d.acc  = 1'b0;
    end

    if (access_err)
      st_d.acc = 1'b1;

    // New error wins over clears in the same cycle
    if (range_hit)
    begin
      st_d.code = range_code;
      st_d.flag = 1'b1;
      st_d.bad  = 1'b0;
    end
    else if (init_write_done)
      st_d.bad = 1'b0;
    if (err_valid)
    begin
      st_d.code = err_code;
      st_d.flag = 1'b1;
    end
    if (access_err)
    begin
      st_d.code = `ECS_ACCESS_CODE;
      st_d.flag = 1'b1;
    end

    // Sync sequencer: one command pulse, then wait for the store
    unique case (st_q.state)
      ECS_IDLE:
      begin
        if (load_trig)
        begin
          st_d.state = ECS_LOAD;
          st_d.init_pend = 1'b0;
        end
        else if (rewrite_req)
          st_d.state = ECS_SAVE;
      end
      ECS_LOAD:
      begin
        st_d.cmd.load = 1'b1;
        st_d.state = ECS_WAIT;
      end
      ECS_SAVE:
      begin
        st_d.cmd.save = 1'b1;
        st_d.state = ECS_WAIT;
      end
      ECS_WAIT:
      begin
        if (wait_exit)
          st_d.state = ECS_IDLE;
      end
      default: st_d.state = ECS_IDLE;
    endcase

    // Registered so the port comes from a flip-flop
    st_d.busy = (st_d.state != ECS_IDLE);
    st_d.led = st_q.acc ? blink : st_q.flag;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // Power-on: code zero, copy-out pending
      st_q <= '0;
      st_q.state <= ECS_IDLE;
      st_q.code <= `ECS_ERR_NONE;
      st_q.init_pend <= 1'b1;
    end
    else if (clk_en)
      st_q <= st_d;
  end

  assign err_code_word = st_q.code;
  assign err_flag      = st_q.flag;
  assign err_led       = st_q.led;
  assign sync_cmd      = st_q.cmd;
  assign busy          = st_q.busy;
endmodule
`default_nettype wire

// ===== ecs_sva.sv
// Assertions on the error code block ports
`timescale 1ns/1ps
`default_nettype none
`include "ecs_params.svh"
module ecs_sva (
  input wire logic        sys_clk, nrst, clk_en, host_reset, power_ok, error_clear_request,
  input wire logic        err_valid, access_err, init_write_done, rewrite_req, busy, err_flag,
  input wire logic [15:0] err_code, err_code_word,
  input wire ecs_pkg::ecs_sync_t sync_cmd
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst || !clk_en);
  wire ev = err_valid | access_err | init_write_done;
  wire idle = !ev && !host_reset && power_ok && !error_clear_request;
  sequence s_req;
    $rose(error_clear_request) && !ev ##1 (error_clear_request && !ev)[*4];
  endsequence
  sequence s_save;
    busy ##1 sync_cmd.save ##1 !sync_cmd.save;
  endsequence
  AST_LATCH: assert property (err_valid && !access_err |=> err_code_word == $past(err_code))
    else $error("code not latched");
  AST_HOLD: assert property (idle |=> $stable(err_code_word))
    else $error("code changed");
  AST_ACC: assert property (access_err |=> err_code_word == `ECS_ACCESS_CODE)
    else $error("access code");
  AST_HRST: assert property (host_reset && !ev |=> err_code_word == 16'h0000)
    else $error("host reset clear");
  AST_PWR: assert property (!power_ok && !ev |=> err_code_word == 16'h0000)
    else $error("power clear");
  AST_FLAG: assert property ($fell(host_reset) && !ev |=> !err_flag)
    else $error("flag kept");
  AST_REQ: assert property (s_req |-> ##[1:2] err_code_word == 16'h0000)
    else $error("request clear");
  AST_SAVE: assert property (rewrite_req && !busy && !host_reset && $past(nrst) |=> s_save)
    else $error("rewrite walk");
endmodule
bind ecs_top ecs_sva u_sva (.*);
`default_nettype wire

// ===== ecs_host_model.sv
// Host store model answering sync commands
`timescale 1ns/1ps
`default_nettype none
module ecs_host_model #(parameter int DLY = 3) (
  input wire logic               sys_clk, nrst,
  input wire ecs_pkg::ecs_sync_t sync_cmd,
  output logic                   store_done
);
  int cnt_q;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst) cnt_q <= 0;
    else if (sync_cmd.load || sync_cmd.save) cnt_q <= DLY;
    else if (cnt_q > 0) cnt_q <= cnt_q - 1;
    if (!nrst) store_done <= 1'b0;
    else store_done <= (cnt_q == 1);
  end
endmodule
`default_nettype wire

// ===== error_code_and_setting_sync_tb.sv
// Testbench for the error code and setting sync block
`timescale 1ns/1ps
`default_nettype none
module error_code_and_setting_sync_tb;
  import ecs_pkg::*;
  logic sys_clk = 0, nrst = 0, hr = 0, hs = 0, pw = 1, clr = 0, ce = 1;
  logic ev = 0, acc = 0, iwd = 0, rw = 0, sd, flag, led, busy;
  logic [15:0] code = 0, word;
  ecs_wr_t wr = '0;
  ecs_sync_t sc;
  int err_count = 0, checks = 0, cyc = 0, saves = 0, loads = 0;
  initial forever #4 sys_clk = ~sys_clk;
  ecs_top #(.BLINK_HALF(4)) dut_u (.sys_clk(sys_clk), .nrst(nrst), .clk_en(ce),
    .host_reset(hr), .host_stopped(hs), .power_ok(pw), .error_clear_request(clr),
    .err_valid(ev), .err_code(code), .access_err(acc), .buf_wr(wr),
    .init_write_done(iwd), .rewrite_req(rw), .store_done(sd), .err_code_word(word),
    .err_flag(flag), .err_led(led), .sync_cmd(sc), .busy(busy));
  ecs_host_model host_u (.sys_clk(sys_clk), .nrst(nrst), .sync_cmd(sc), .store_done(sd));
  task end_of_test;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    saves += sc.save;
    loads += sc.load;
    if (cyc == 3000)
    begin
      err_count++;
      end_of_test;
    end
  end
  task chk(input logic [15:0] s, e);
    checks++;
    if (s !== e)
    begin
      err_count++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask
  task nc(input int n); repeat (n) @(negedge sys_clk); endtask
  task put(input logic [15:0] c); code = c; ev = 1; nc(1); ev = 0; nc(1); endtask
  task t_latch;
    nc(20);
    chk(word, 16'h0000);
    chk(16'(loads), 16'h0001);
    put(16'h1234);
    chk(word, 16'h1234);
    put(16'h0055);
    nc(10);
    chk(word, 16'h0055);
  endtask
  task t_clear;
    clr = 1; nc(2); clr = 0; nc(8);
    chk(word, 16'h0055);
    clr = 1; nc(7); clr = 0;
    chk(word, 16'h0000);
  endtask
  task t_range;
    wr = '{1'b1, 16'h06d7, 16'h0002}; nc(1); wr.valid = 0;
    iwd = 1; nc(1); iwd = 0; nc(2);
    chk(word, 16'h0abf);
    chk(16'(saves), 16'h0000);
    rw = 1; nc(1); rw = 0; nc(10);
    chk(16'(saves), 16'h0001);
    chk(busy, 1'b0);
    wr = '{1'b1, 16'h06d5, 16'h2710}; nc(1);
    wr = '{1'b1, 16'h06d6, 16'h2710}; nc(1); wr.valid = 0;
    iwd = 1; nc(1); iwd = 0; nc(1);
    chk(word, 16'h0abd);
    wr = '{1'b1, 16'h06d6, 16'h270f}; nc(1); wr.valid = 0;
    iwd = 1; nc(1); iwd = 0; nc(1);
    chk(word, 16'h0abd);
  endtask
  task t_access;
    int t;
    logic b;
    t = 0;
    acc = 1; nc(1); acc = 0; nc(1);
    chk(word, 16'h0001);
    b = led;
    repeat (12) begin nc(1); t += (led !== b); b = led; end
    chk(t != 0, 1'b1);
  endtask
  task t_host;
    chk(flag, 1'b1);
    hr = 1; hs = 1; nc(3);
    chk(word, 16'h0000);
    hr = 0; hs = 0; nc(2);
    chk(flag, 1'b0);
    nc(10);
    chk(loads > 1, 1'b1);
    put(16'h0077);
    pw = 0; nc(2); pw = 1;
    chk(word, 16'h0000);
    hr = 1; hs = 0; nc(3); hr = 0; nc(10);
    chk(16'(loads), 16'h0002);
    ce = 0; put(16'h00aa); ce = 1; nc(1);
    chk(word, 16'h0000);
  endtask
  initial
  begin
    nc(4);
    nrst = 1;
    t_latch;
    t_clear;
    t_range;
    t_access;
    t_host;
    end_of_test;
  end
endmodule
`default_nettype wire
